// [include/tpcs_pkg.sv]
// ==========================================================================
// Shared prescaler and clock select: constants and types
// ==========================================================================
package tpcs_pkg;

  // ========================================================================
  // Bus geometry
  // ========================================================================
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] GTC_INDEX = 12'h043;
  localparam logic [ADDR_W-1:0] CSEL_INDEX = 12'h044;
  localparam logic [ADDR_W-1:0] STAT_INDEX = 12'h045;
  localparam logic [ADDR_W-1:0] GTC_ADDR = 12'h10c;
  localparam logic [ADDR_W-1:0] CSEL_ADDR = 12'h110;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h114;

  // Write and read responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ========================================================================
  // Control register layout
  // ========================================================================
  localparam int unsigned GTC_TSM_BIT = 7;
  localparam int unsigned GTC_ASYNC_PRESCALER_RESET_BIT = 1;
  localparam int unsigned GTC_SYNC_PRESCALER_RESET_BIT = 0;
  localparam logic [7:0] GTC_RESET = 8'h00;

  // Clock select register: timer 0 in [2:0], timer 1 in [6:4]
  localparam int unsigned CS_W = 3;
  localparam int unsigned CSEL_T0_LSB = 0;
  localparam int unsigned CSEL_T1_LSB = 4;

  // Status register: prescaler count in [9:0], pin levels in [17:16]
  localparam int unsigned STAT_PIN_LSB = 16;

  // ========================================================================
  // Prescaler
  // ========================================================================
  localparam int unsigned PRESC_W = 10;
  localparam int unsigned NUM_TIMERS = 2;
  localparam int unsigned TAP8_W = 3;
  localparam int unsigned TAP64_W = 6;
  localparam int unsigned TAP256_W = 8;
  localparam int unsigned TAP1024_W = 10;

  // Clock select codes
  typedef enum logic [CS_W-1:0] {
    CS_STOP = 3'h0,
    CS_SYSCLK = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } tpcs_cs_t;

  // Bus channel states
  typedef enum logic [1:0] {
    CH_WAIT = 2'h1,
    CH_RESP = 2'h2
  } tpcs_ch_state_t;

  // Control register bits
  typedef struct packed {
    logic timer_sync_hold;
    logic async_prescaler_reset;
    logic sync_prescaler_reset;
  } tpcs_gtc_t;

endpackage : tpcs_pkg

// [hdl/tpcs_pin_edge.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Count pin synchroniser and edge detector
// ==========================================================================
module tpcs_pin_edge (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic level_q;

  // Three stages; only the second and third are ever compared
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Accepted level moves only once stages two and three agree
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      level_q <= 1'b0;
    else if (sync2_q == sync3_q)
      level_q <= sync3_q;
  end

  // One pulse per accepted change of level
  assign rise_out = (sync2_q == sync3_q) && sync3_q && !level_q;
  assign fall_out = (sync2_q == sync3_q) && !sync3_q && level_q;
  assign level_out = level_q;

endmodule : tpcs_pin_edge
`default_nettype wire

// [hdl/tpcs_top.sv]
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Shared prescaler and clock select for two timers
// ==========================================================================
module tpcs_top #(
  parameter int unsigned PRESC_WIDTH = tpcs_pkg::PRESC_W
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [tpcs_pkg::ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic [2:0] s_axi_awprot_in,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  input wire logic [tpcs_pkg::DATA_W-1:0] s_axi_wdata_in,
  input wire logic [tpcs_pkg::STRB_W-1:0] s_axi_wstrb_in,
  // AXI4-Lite write response
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  output logic [1:0] s_axi_bresp_out,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  input wire logic [tpcs_pkg::ADDR_W-1:0] s_axi_araddr_in,
  input wire logic [2:0] s_axi_arprot_in,
  // AXI4-Lite read data
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic [tpcs_pkg::DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  // External count pins, one per timer
  input wire logic [tpcs_pkg::NUM_TIMERS-1:0] external_count_pin_in,
  // One-cycle count enables, one per timer
  output logic [tpcs_pkg::NUM_TIMERS-1:0] timer_count_clock_out,
  // Reset level for the separate asynchronous timer prescaler
  output logic async_prescaler_reset_out
);

  // ========================================================================
  // Helpers
  // ========================================================================
  // Tap fires when the low w bits of the prescaler are all ones
  function automatic logic tap_hit(input logic [PRESC_WIDTH-1:0] cnt,
                                   input int unsigned w);
    return (cnt | ~PRESC_WIDTH'((32'h1 << w) - 32'h1)) == '1;
  endfunction : tap_hit

  // Byte address to register word index
  function automatic logic [tpcs_pkg::ADDR_W-1:0] word_index(
    input logic [tpcs_pkg::ADDR_W-1:0] addr);
    return {2'h0, addr[tpcs_pkg::ADDR_W-1:2]};
  endfunction : word_index

  // ========================================================================
  // Declarations
  // ========================================================================
  tpcs_pkg::tpcs_gtc_t gtc_q;
  logic [2*tpcs_pkg::CS_W-1:0] csel_q;
  logic [PRESC_WIDTH-1:0] presc_q;
  logic [3:0] taps;
  logic [tpcs_pkg::NUM_TIMERS-1:0] pin_level;
  logic [tpcs_pkg::NUM_TIMERS-1:0] pin_rise;
  logic [tpcs_pkg::NUM_TIMERS-1:0] pin_fall;
  logic [tpcs_pkg::NUM_TIMERS-1:0] count_d;
  logic [tpcs_pkg::NUM_TIMERS-1:0] count_q;
  tpcs_pkg::tpcs_ch_state_t wr_state_q;
  tpcs_pkg::tpcs_ch_state_t rd_state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [tpcs_pkg::ADDR_W-1:0] awaddr_q;
  logic [tpcs_pkg::DATA_W-1:0] wdata_q;
  logic [tpcs_pkg::STRB_W-1:0] wstrb_q;
  logic [1:0] bresp_q;
  logic [tpcs_pkg::DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic aw_hs;
  logic w_hs;
  logic wr_fire;
  logic [tpcs_pkg::ADDR_W-1:0] wr_addr;
  logic [tpcs_pkg::DATA_W-1:0] wr_data;
  logic [tpcs_pkg::STRB_W-1:0] wr_strb;
  logic wr_gtc;
  logic wr_csel;
  logic wr_hit;
  logic ar_hs;
  logic presc_reset;

  // ========================================================================
  // Write channels
  // ========================================================================
  // Address and data are taken independently, in either order
  assign s_axi_awready_out = (wr_state_q == tpcs_pkg::CH_WAIT) && !aw_got_q;
  assign s_axi_wready_out = (wr_state_q == tpcs_pkg::CH_WAIT) && !w_got_q;
  assign aw_hs = s_axi_awvalid_in && s_axi_awready_out;
  assign w_hs = s_axi_wvalid_in && s_axi_wready_out;
  assign wr_fire = (aw_got_q || aw_hs) && (w_got_q || w_hs);
  assign wr_addr = aw_got_q ? awaddr_q : s_axi_awaddr_in;
  assign wr_data = w_got_q ? wdata_q : s_axi_wdata_in;
  assign wr_strb = w_got_q ? wstrb_q : s_axi_wstrb_in;

  // Decode; writable registers live in byte lane 0 only
  assign wr_gtc = wr_fire && (word_index(wr_addr) == tpcs_pkg::GTC_INDEX)
                  && (wr_addr[1:0] == 2'h0);
  assign wr_csel = wr_fire && (word_index(wr_addr) == tpcs_pkg::CSEL_INDEX)
                   && (wr_addr[1:0] == 2'h0);
  assign wr_hit = wr_gtc || wr_csel ||
                  (wr_addr == tpcs_pkg::STAT_ADDR);

  // Hold whichever half arrives first
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else if (wr_fire)
    begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
    end
    else
    begin
      if (aw_hs)
      begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_in;
      end
      if (w_hs)
      begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
    end
  end

  // Response follows both halves; status writes are ignored but okay
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      wr_state_q <= tpcs_pkg::CH_WAIT;
      bresp_q <= tpcs_pkg::RESP_OKAY;
    end
    else
    begin
      unique case (wr_state_q)
        tpcs_pkg::CH_WAIT:
        begin
          if (wr_fire)
          begin
            wr_state_q <= tpcs_pkg::CH_RESP;
            bresp_q <= wr_hit ? tpcs_pkg::RESP_OKAY : tpcs_pkg::RESP_SLVERR;
          end
        end
        tpcs_pkg::CH_RESP:
        begin
          if (s_axi_bready_in)
            wr_state_q <= tpcs_pkg::CH_WAIT;
        end
        default:
          wr_state_q <= tpcs_pkg::CH_WAIT;
      endcase
    end
  end

  assign s_axi_bvalid_out = (wr_state_q == tpcs_pkg::CH_RESP);
  assign s_axi_bresp_out = bresp_q;

  // ========================================================================
  // Read channel
  // ========================================================================
  assign s_axi_arready_out = (rd_state_q == tpcs_pkg::CH_WAIT);
  assign ar_hs = s_axi_arvalid_in && s_axi_arready_out;

  // Data captured at the address edge, shown the next cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
    begin
      rd_state_q <= tpcs_pkg::CH_WAIT;
      rdata_q <= '0;
      rresp_q <= tpcs_pkg::RESP_OKAY;
    end
    else
    begin
      unique case (rd_state_q)
        tpcs_pkg::CH_WAIT:
        begin
          if (ar_hs)
          begin
            rd_state_q <= tpcs_pkg::CH_RESP;
            rresp_q <= tpcs_pkg::RESP_OKAY;
            unique case (s_axi_araddr_in)
              tpcs_pkg::GTC_ADDR:
              begin
                rdata_q <= '0;
                rdata_q[tpcs_pkg::GTC_TSM_BIT] <= gtc_q.timer_sync_hold;
                rdata_q[tpcs_pkg::GTC_ASYNC_PRESCALER_RESET_BIT] <= gtc_q.async_prescaler_reset;
                rdata_q[tpcs_pkg::GTC_SYNC_PRESCALER_RESET_BIT] <= gtc_q.sync_prescaler_reset;
              end
              tpcs_pkg::CSEL_ADDR:
              begin
                rdata_q <= '0;
                rdata_q[tpcs_pkg::CSEL_T0_LSB +: tpcs_pkg::CS_W] <=
                  csel_q[0 +: tpcs_pkg::CS_W];
                rdata_q[tpcs_pkg::CSEL_T1_LSB +: tpcs_pkg::CS_W] <=
                  csel_q[tpcs_pkg::CS_W +: tpcs_pkg::CS_W];
              end
              tpcs_pkg::STAT_ADDR:
              begin
                // Live prescaler phase helps software predict first count
                rdata_q <= '0;
                rdata_q[PRESC_WIDTH-1:0] <= presc_q;
                rdata_q[tpcs_pkg::STAT_PIN_LSB +: tpcs_pkg::NUM_TIMERS] <=
                  pin_level;
              end
              default:
              begin
                rdata_q <= '0;
                rresp_q <= tpcs_pkg::RESP_SLVERR;
              end
            endcase
          end
        end
        tpcs_pkg::CH_RESP:
        begin
          if (s_axi_rready_in)
            rd_state_q <= tpcs_pkg::CH_WAIT;
        end
        default:
          rd_state_q <= tpcs_pkg::CH_WAIT;
      endcase
    end
  end

  assign s_axi_rvalid_out = (rd_state_q == tpcs_pkg::CH_RESP);
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // ========================================================================
  // Control registers
  // ========================================================================
  // Reset bits self-clear one cycle after a write unless held;
  // a write in the same cycle wins over the hardware clear
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      gtc_q <= tpcs_pkg::tpcs_gtc_t'(tpcs_pkg::GTC_RESET[2:0]);
    else if (wr_gtc && wr_strb[0])
    begin
      gtc_q.timer_sync_hold <= wr_data[tpcs_pkg::GTC_TSM_BIT];
      gtc_q.async_prescaler_reset <= wr_data[tpcs_pkg::GTC_ASYNC_PRESCALER_RESET_BIT];
      gtc_q.sync_prescaler_reset <= wr_data[tpcs_pkg::GTC_SYNC_PRESCALER_RESET_BIT];
    end
    else if (!gtc_q.timer_sync_hold)
    begin
      gtc_q.async_prescaler_reset <= 1'b0;
      gtc_q.sync_prescaler_reset <= 1'b0;
    end
  end

  // Clock select fields for both timers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      csel_q <= '0;
    else if (wr_csel && wr_strb[0])
      csel_q <= {wr_data[tpcs_pkg::CSEL_T1_LSB +: tpcs_pkg::CS_W],
                 wr_data[tpcs_pkg::CSEL_T0_LSB +: tpcs_pkg::CS_W]};
  end

  assign presc_reset = gtc_q.sync_prescaler_reset;
  assign async_prescaler_reset_out = gtc_q.async_prescaler_reset;

  // ========================================================================
  // Shared prescaler
  // ========================================================================
  // Free running, ignores clock select; reset hits both timers
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      presc_q <= '0;
    else if (presc_reset)
      presc_q <= '0;
    else
      presc_q <= presc_q + 1'b1;
  end

  // Taps stay quiet while the prescaler is held in reset
  assign taps[0] = !presc_reset && tap_hit(presc_q, tpcs_pkg::TAP8_W);
  assign taps[1] = !presc_reset && tap_hit(presc_q, tpcs_pkg::TAP64_W);
  assign taps[2] = !presc_reset && tap_hit(presc_q, tpcs_pkg::TAP256_W);
  assign taps[3] = !presc_reset && tap_hit(presc_q, tpcs_pkg::TAP1024_W);

  // ========================================================================
  // External count pins
  // ========================================================================
  for (genvar t = 0; t < tpcs_pkg::NUM_TIMERS; t++)
  begin : g_pin
    tpcs_pin_edge u_pin_edge (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .pin_in(external_count_pin_in[t]),
      .level_out(pin_level[t]),
      .rise_out(pin_rise[t]),
      .fall_out(pin_fall[t])
    );
  end

  // ========================================================================
  // Clock select
  // ========================================================================
  // Sync reset halts every source so both timers restart together
  always_comb
  begin
    count_d = '0;
    for (int unsigned t = 0; t < tpcs_pkg::NUM_TIMERS; t++)
    begin
      unique case (tpcs_pkg::tpcs_cs_t'(csel_q[t*tpcs_pkg::CS_W +:
                                               tpcs_pkg::CS_W]))
        tpcs_pkg::CS_STOP: count_d[t] = 1'b0;
        tpcs_pkg::CS_SYSCLK: count_d[t] = !presc_reset;
        tpcs_pkg::CS_DIV8: count_d[t] = taps[0];
        tpcs_pkg::CS_DIV64: count_d[t] = taps[1];
        tpcs_pkg::CS_DIV256: count_d[t] = taps[2];
        tpcs_pkg::CS_DIV1024: count_d[t] = taps[3];
        // Pin edges go straight through, never divided
        tpcs_pkg::CS_EXT_FALL: count_d[t] = !presc_reset && pin_fall[t];
        tpcs_pkg::CS_EXT_RISE: count_d[t] = !presc_reset && pin_rise[t];
      endcase
    end
  end

  // Registered enables keep the output free of decode glitches
  always_ff @(posedge ref_clk_in)
  begin
    if (reset_in)
      count_q <= '0;
    else
      count_q <= count_d;
  end

  assign timer_count_clock_out = count_q;
endmodule : tpcs_top
`default_nettype wire

// [verif/tpcs_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Port checker for the shared prescaler block
// ==========================================================================
module tpcs_checker #(
  parameter int unsigned PRESC_WIDTH = 10
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] timer_count_clock_out
);
  // All checks share the one clock domain
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  // Reset silences count enables and responses
  a_reset_quiet: assert property (disable iff (1'b0) reset_in |=>
    timer_count_clock_out == 2'h0 && !s_axi_bvalid_out && !s_axi_rvalid_out)
    else $error("outputs active after reset edge");
  a_bresp_holds: assert property (s_axi_bvalid_out && !s_axi_bready_in |=>
    s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");
  a_rdata_holds: assert property (s_axi_rvalid_out && !s_axi_rready_in |=>
    s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before taken");
  a_write_answer: assert property (s_axi_awvalid_in && s_axi_awready_out &&
    s_axi_wvalid_in && s_axi_wready_out |=> s_axi_bvalid_out)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid_in && s_axi_arready_out |=>
    s_axi_rvalid_out)
    else $error("read data late");
  a_read_refused: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  a_write_refused: assert property (s_axi_bvalid_out |->
    !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  a_b_single: assert property (s_axi_bvalid_out && s_axi_bready_in |=>
    !s_axi_bvalid_out)
    else $error("write response repeated");
endmodule : tpcs_checker

bind tpcs_top tpcs_checker #(.PRESC_WIDTH(PRESC_WIDTH)) u_chk (
  .ref_clk_in(ref_clk_in),
  .reset_in(reset_in),
  .s_axi_awvalid_in(s_axi_awvalid_in),
  .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in),
  .s_axi_bresp_out(s_axi_bresp_out),
  .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out),
  .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in),
  .s_axi_rdata_out(s_axi_rdata_out),
  .timer_count_clock_out(timer_count_clock_out)
);
`default_nettype wire

// [verif/tpcs_ext_source.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// External count source on both count pins
// ==========================================================================
module tpcs_ext_source #(
  parameter int HALF_NS = 150
) (
  input wire logic go_in,
  input wire logic [7:0] periods_in,
  output logic [1:0] pin_out
);
  // Idle low between bursts, so the pin is stable when sources switch
  initial pin_out = 2'h0;
  // Phase offset keeps edges away from the system clock edge
  always @(posedge go_in)
  begin
    #17;
    repeat (periods_in)
    begin
      pin_out = 2'h3;
      #HALF_NS;
      pin_out = 2'h0;
      #HALF_NS;
    end
  end
endmodule : tpcs_ext_source
`default_nettype wire

// [verif/tpcs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Testbench for the shared prescaler block
// ==========================================================================
module tpcs_tb;
  logic clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0;
  logic arv = 1'b0, rry = 1'b0, awr, wr, bv, arr, rv, apr, go = 1'b0;
  logic [11:0] awa = 12'h0, ara = 12'h0;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] br, rr, pins, tcc;
  logic [7:0] np = 8'h0;
  int n_fail = 0, total_checks = 0, cyc = 0, cnt0 = 0, cnt1 = 0, a0, a1;

  tpcs_top uut (.ref_clk_in(clk), .reset_in(rst), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_awprot_in(3'h0),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'hf), .s_axi_bvalid_out(bv), .s_axi_bready_in(bry),
    .s_axi_bresp_out(br), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_arprot_in(3'h0), .s_axi_rvalid_out(rv),
    .s_axi_rready_in(rry), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
    .external_count_pin_in(pins), .timer_count_clock_out(tcc),
    .async_prescaler_reset_out(apr));
  tpcs_ext_source u_src (.go_in(go), .periods_in(np), .pin_out(pins));

  // 20 MHz system clock
  always #25 clk = ~clk;
  // Count enables tallied on the falling edge, away from stimulus
  always @(negedge clk)
  begin
    if (tcc[0] === 1'b1) cnt0++;
    if (tcc[1] === 1'b1) cnt1++;
  end
  // Hang guard, well above the roughly 8500 cycles the tests need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      end_sim();
    end
  end

  // ========================================================================
  // Shared tasks
  // ========================================================================
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles

  // Address and data offered together, each dropped once taken
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [1:0] er);
    logic ad, dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge clk);
    awv <= 1'b1;
    awa <= a;
    wv <= 1'b1;
    wd <= d;
    bry <= 1'b1;
    while (!(ad && dd))
    begin
      @(posedge clk);
      if (!ad && awr === 1'b1) begin ad = 1'b1; awv <= 1'b0; end
      if (!dd && wr === 1'b1) begin dd = 1'b1; wv <= 1'b0; end
    end
    while (bv !== 1'b1) @(posedge clk);
    check({30'h0, br}, {30'h0, er});
    bry <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rry <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clk); while (rv !== 1'b1);
    check(rd, ed);
    check({30'h0, rr}, {30'h0, er});
    rry <= 1'b0;
  endtask : axi_read

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  // ========================================================================
  // Scenarios
  // ========================================================================
  task automatic t_regs();
    axi_read(tpcs_pkg::GTC_ADDR, 32'h0, tpcs_pkg::RESP_OKAY);
    axi_read(12'h200, 32'h0, tpcs_pkg::RESP_SLVERR);
    axi_write(12'h200, 32'hff, tpcs_pkg::RESP_SLVERR);
    $display("registers done");
  endtask : t_regs

  // Every tap on timer 0 while timer 1 stays on divide by 8
  task automatic t_taps();
    int dv[4] = '{8, 64, 256, 1024};
    for (int c = 2; c <= 5; c++)
    begin
      axi_write(tpcs_pkg::CSEL_ADDR, {25'h0, 3'h2, 1'b0, 3'(c)}, 2'h0);
      cycles(2);
      a0 = cnt0;
      a1 = cnt1;
      cycles(2048);
      check(cnt0 - a0, 2048 / dv[c - 2]);
      check(cnt1 - a1, 256);
    end
    $display("taps done");
  endtask : t_taps

  // A prescaler reset restarts both timers' periods
  task automatic t_restart();
    int f0, f1;
    f0 = 0;
    f1 = 0;
    axi_write(tpcs_pkg::CSEL_ADDR, 32'h32, tpcs_pkg::RESP_OKAY);
    axi_write(tpcs_pkg::GTC_ADDR, 32'h1, tpcs_pkg::RESP_OKAY);
    for (int i = 1; i <= 70; i++)
    begin
      @(posedge clk);
      if (f0 == 0 && tcc[0] === 1'b1) f0 = i;
      if (f1 == 0 && tcc[1] === 1'b1) f1 = i;
    end
    check(32'(f0 >= 1 && f0 <= 9), 32'h1);
    check(32'(f1 >= 56 && f1 <= 65), 32'h1);
    $display("restart done");
  endtask : t_restart

  task automatic t_hold();
    axi_write(tpcs_pkg::CSEL_ADDR, 32'h01, tpcs_pkg::RESP_OKAY);
    a0 = cnt0;
    a1 = cnt1;
    cycles(20);
    check(cnt0 - a0, 20);
    check(cnt1 - a1, 0);
    axi_write(tpcs_pkg::GTC_ADDR, 32'h01, tpcs_pkg::RESP_OKAY);
    axi_read(tpcs_pkg::GTC_ADDR, 32'h0, tpcs_pkg::RESP_OKAY);
    axi_write(tpcs_pkg::GTC_ADDR, 32'h83, tpcs_pkg::RESP_OKAY);
    axi_read(tpcs_pkg::GTC_ADDR, 32'h83, tpcs_pkg::RESP_OKAY);
    check({31'h0, apr}, 32'h1);
    a0 = cnt0;
    cycles(50);
    check(cnt0 - a0, 0);
    axi_write(tpcs_pkg::CSEL_ADDR, 32'h11, tpcs_pkg::RESP_OKAY);
    axi_write(tpcs_pkg::GTC_ADDR, 32'h03, tpcs_pkg::RESP_OKAY);
    axi_read(tpcs_pkg::GTC_ADDR, 32'h0, tpcs_pkg::RESP_OKAY);
    check({31'h0, apr}, 32'h0);
    a0 = cnt0;
    a1 = cnt1;
    cycles(20);
    check(cnt0 - a0, 20);
    check(cnt1 - a1, 20);
    $display("hold done");
  endtask : t_hold

  // Six source periods: one count per rising or falling edge, undivided
  task automatic t_ext();
    axi_write(tpcs_pkg::CSEL_ADDR, 32'h67, tpcs_pkg::RESP_OKAY);
    a0 = cnt0;
    a1 = cnt1;
    np <= 8'h6;
    go <= 1'b1;
    cycles(48);
    go <= 1'b0;
    check(cnt0 - a0, 6);
    check(cnt1 - a1, 6);
    $display("external done");
  endtask : t_ext

  // Main sequence
  initial
  begin
    cycles(8);
    rst <= 1'b0;
    t_regs();
    t_taps();
    t_restart();
    t_hold();
    t_ext();
    end_sim();
  end
endmodule : tpcs_tb
`default_nettype wire
